/* File: verilog/tdm_irq_pkg.sv */
package tdm_irq_pkg;
   localparam int unsigned NUM_SRC      = 8;
   localparam int unsigned PTR_W        = 12;
   localparam int unsigned SRC_BUS      = 0;
   localparam int unsigned SRC_HALF     = 1;
   localparam int unsigned SRC_END      = 2;
   localparam int unsigned SRC_STEP     = 3;
   localparam int unsigned SRC_HOLD_A   = 4;
   localparam int unsigned SRC_HOLD_B   = 5;
   localparam int unsigned SRC_ACT      = 6;
   localparam int unsigned SRC_ERR      = 7;
   localparam logic [7:0]  STATUS_RESET = 8'h00;
   localparam logic [11:0] PTR_RESET    = 12'h000;
   typedef enum logic [0:0] {DMA_IDLE, DMA_RUN} dma_state_t;
endpackage

/* File: verilog/irq_flag_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface irq_flag_if;
   logic [7:0] event_set;
   logic [7:0] clear;
   logic [7:0] enable;
   logic [7:0] status;
   logic       irq;
   modport owner (input event_set, clear, enable, output status, irq);
   modport user  (output event_set, clear, enable, input status, irq);
endinterface
`default_nettype wire

/* File: verilog/irq_flag_bank.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_flag_bank #(
   parameter int unsigned N = 8
) (
   input  wire logic sys_clk_in,  // Bus clock
   input  wire logic rst_in,      // Sync reset, high
   irq_flag_if.owner fl           // Flag group
);
   logic [7:0] flag;
   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_flag
         always_ff @(posedge sys_clk_in) begin
            if (rst_in)
               flag[i] <= tdm_irq_pkg::STATUS_RESET[i];
            else if (fl.event_set[i])
               flag[i] <= 1'b1;
            else if (fl.clear[i])
               flag[i] <= 1'b0;
         end
      end
   endgenerate
   assign fl.status = flag;
   assign fl.irq    = |(flag & fl.enable);

   AST_FLAG_STICKS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (flag[0] && !fl.clear[0]) |=> flag[0]) else $error("flag dropped without clear");
   AST_MASK_GATES: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (fl.enable == 8'h00) |-> !fl.irq) else $error("masked flag raised request");
   AST_IRQ_OR: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      ((flag & fl.enable) != 8'h00) |-> fl.irq) else $error("enabled flag missing from request");
   AST_SET_WINS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      fl.event_set[1] |=> flag[1]) else $error("event lost");
endmodule
`default_nettype wire

/* File: verilog/tdm_port_interrupt_logic.sv */
// Notes on behaviour
// - The eight enabled status flags are ORed into one request to the chip interrupt controller.
// - A readable status word holds one flag per source, and each source has its own enable bit.
// - A DMA transfer ending in a bus error sets the bus fault flag.
// - The pointer reaching the buffer midpoint sets the half buffer flag.
// - The pointer reaching the last buffer location sets the buffer end flag.
// - Every pointer increment sets the pointer step flag.
// - A valid sample in receive holding register A sets the holding A flag.
// - A valid sample in receive holding register B sets the holding B flag.
// - Detected toggling of the serial port clock sets the link activity flag.
// - Refilling a receive holding register before it was read sets the error flag.
// - Emptying a transmit holding register before it was rewritten sets the error flag.
// - The current DMA pointer is readable as a 12-bit count.
// - Both modes wrap the pointer to start after the end; one-time mode also stops DMA there.
`timescale 1ns/1ps
`default_nettype none
module tdm_port_interrupt_logic #(
   parameter int unsigned PTR_W = tdm_irq_pkg::PTR_W
) (
   input  wire logic             sys_clk_in,          // Bus clock, 10 MHz
   input  wire logic             rst_in,              // Sync reset, high
   input  wire logic             dma_enable_in,       // Start DMA pointer walk
   input  wire logic             circular_mode_in,    // 1 circular, 0 one-time
   input  wire logic [PTR_W-1:0] buffer_last_in,      // Index of last buffer entry
   input  wire logic             dma_ack_in,          // One sample moved by DMA
   input  wire logic             dma_bus_fault_in,    // DMA ended with bus error
   input  wire logic             holding_a_fill_in,   // RX holding A loaded by hardware
   input  wire logic             holding_a_read_in,   // RX holding A read by CPU/DMA
   input  wire logic             holding_b_fill_in,   // RX holding B loaded by hardware
   input  wire logic             holding_b_read_in,   // RX holding B read by CPU/DMA
   input  wire logic             tx_empty_a_in,       // TX holding A emptied by hardware
   input  wire logic             tx_write_a_in,       // TX holding A written by CPU/DMA
   input  wire logic             tx_empty_b_in,       // TX holding B emptied by hardware
   input  wire logic             tx_write_b_in,       // TX holding B written by CPU/DMA
   input  wire logic             serial_port_clock_in,// Serial clock, sampled
   input  wire logic [7:0]       irq_enable_in,       // Per-source enable bits
   input  wire logic [7:0]       irq_clear_in,        // Per-source clear pulses
   output logic      [7:0]       port_irq_status_out, // Status flags
   output logic                  chip_irq_out,        // Combined request
   output logic      [PTR_W-1:0] dma_pointer_out,     // Current DMA pointer
   output logic                  dma_active_out       // DMA running
);
   irq_flag_if fl ();

   tdm_irq_pkg::dma_state_t state;
   tdm_irq_pkg::dma_state_t next_state;
   logic [PTR_W-1:0] ptr;
   logic [PTR_W-1:0] next_ptr;
   logic             rx_full_a;
   logic             rx_full_b;
   logic             tx_full_a;
   logic             tx_full_b;
   logic             clk_prev;
   logic             clk_seen;
   logic             en_prev;

   wire step      = (state == tdm_irq_pkg::DMA_RUN) && dma_ack_in;
   wire at_end    = (ptr == buffer_last_in);
   wire [PTR_W-1:0] half_point = buffer_last_in >> 1;
   wire at_half   = (ptr == half_point);
   wire overrun   = (holding_a_fill_in && rx_full_a && !holding_a_read_in)
                  || (holding_b_fill_in && rx_full_b && !holding_b_read_in);
   wire underrun  = (tx_empty_a_in && !tx_full_a && !tx_write_a_in)
                  || (tx_empty_b_in && !tx_full_b && !tx_write_b_in);
   wire toggle    = clk_seen && (clk_prev != serial_port_clock_in);
   // Only a rising enable starts a walk, so a one-time stop stays stopped
   wire start     = dma_enable_in && !en_prev;

   always_comb begin
      next_state = state;
      next_ptr   = ptr;
      unique case (state)
         tdm_irq_pkg::DMA_IDLE: begin
            if (start) begin
               next_state = tdm_irq_pkg::DMA_RUN;
               next_ptr   = '0;
            end
         end
         tdm_irq_pkg::DMA_RUN: begin
            if (!dma_enable_in)
               next_state = tdm_irq_pkg::DMA_IDLE;
            else if (step && at_end) begin
               next_ptr = '0;
               if (!circular_mode_in)
                  next_state = tdm_irq_pkg::DMA_IDLE;
            end else if (step)
               next_ptr = ptr + 1'b1;
         end
      endcase
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state <= tdm_irq_pkg::DMA_IDLE;
         ptr   <= tdm_irq_pkg::PTR_RESET[PTR_W-1:0];
      end else begin
         state <= next_state;
         ptr   <= next_ptr;
      end
   end

   // Holding register occupancy for overrun and underrun detection, plus serial clock and enable history
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         rx_full_a <= 1'b0;
         rx_full_b <= 1'b0;
         tx_full_a <= 1'b1;
         tx_full_b <= 1'b1;
         clk_prev  <= 1'b0;
         clk_seen  <= 1'b0;
         en_prev   <= 1'b0;
      end else begin
         rx_full_a <= holding_a_fill_in | (rx_full_a & ~holding_a_read_in);
         rx_full_b <= holding_b_fill_in | (rx_full_b & ~holding_b_read_in);
         tx_full_a <= tx_write_a_in | (tx_full_a & ~tx_empty_a_in);
         tx_full_b <= tx_write_b_in | (tx_full_b & ~tx_empty_b_in);
         clk_prev  <= serial_port_clock_in;
         clk_seen  <= 1'b1;
         en_prev   <= dma_enable_in;
      end
   end

   assign fl.event_set[tdm_irq_pkg::SRC_BUS]    = dma_bus_fault_in;
   assign fl.event_set[tdm_irq_pkg::SRC_HALF]   = step && at_half;
   assign fl.event_set[tdm_irq_pkg::SRC_END]    = step && at_end;
   assign fl.event_set[tdm_irq_pkg::SRC_STEP]   = step;
   assign fl.event_set[tdm_irq_pkg::SRC_HOLD_A] = holding_a_fill_in;
   assign fl.event_set[tdm_irq_pkg::SRC_HOLD_B] = holding_b_fill_in;
   assign fl.event_set[tdm_irq_pkg::SRC_ACT]    = toggle;
   assign fl.event_set[tdm_irq_pkg::SRC_ERR]    = overrun || underrun;
   assign fl.clear  = irq_clear_in;
   assign fl.enable = irq_enable_in;

   irq_flag_bank #(.N(tdm_irq_pkg::NUM_SRC)) u_flags (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .fl         (fl)
   );

   assign port_irq_status_out = fl.status;
   assign chip_irq_out        = fl.irq;
   assign dma_pointer_out     = ptr;
   assign dma_active_out      = (state == tdm_irq_pkg::DMA_RUN);

   AST_BUS_SETS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      dma_bus_fault_in |=> port_irq_status_out[0]) else $error("bus fault flag not set");
   AST_HALF_SETS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (step && ptr == (buffer_last_in >> 1)) |=> port_irq_status_out[1])
      else $error("half flag not set");
   AST_END_SETS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (step && ptr == buffer_last_in && dma_enable_in) |=> port_irq_status_out[2] && ptr == '0)
      else $error("end flag or wrap wrong");
   AST_STEP_INC: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (step && ptr != buffer_last_in && dma_enable_in) |=>
      (port_irq_status_out[3] && ptr == $past(ptr) + 1'b1)) else $error("step wrong");
   AST_HOLD_A: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      holding_a_fill_in |=> port_irq_status_out[4]) else $error("holding A flag not set");
   AST_HOLD_B: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      holding_b_fill_in |=> port_irq_status_out[5]) else $error("holding B flag not set");
   AST_ACT: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      ($changed(serial_port_clock_in) && clk_seen) |=> port_irq_status_out[6])
      else $error("activity flag not set");
   AST_OVERRUN: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (rx_full_a && holding_a_fill_in && !holding_a_read_in) |=> port_irq_status_out[7])
      else $error("overrun not flagged");
   AST_UNDERRUN: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!tx_full_b && tx_empty_b_in && !tx_write_b_in) |=> port_irq_status_out[7])
      else $error("underrun not flagged");
   AST_ONE_TIME_STOP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (step && at_end && !circular_mode_in) |=> !dma_active_out)
      else $error("one-time DMA did not stop");

   // Error flag from the other holding register of each direction
   AST_UNDERRUN_A: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!tx_full_a && tx_empty_a_in && !tx_write_a_in) |=> port_irq_status_out[7])
      else $error("underrun A not flagged");
   AST_OVERRUN_B: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (rx_full_b && holding_b_fill_in && !holding_b_read_in) |=> port_irq_status_out[7])
      else $error("overrun B not flagged");

   // Pointer walk control
   AST_START_ZERO: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!dma_active_out && start) |=> (dma_active_out && dma_pointer_out == '0))
      else $error("DMA start wrong");
   AST_DISABLE_STOPS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (dma_active_out && !dma_enable_in) |=> !dma_active_out)
      else $error("DMA did not stop on disable");
   AST_CIRC_WRAP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (step && at_end && circular_mode_in && dma_enable_in) |=>
      (dma_active_out && dma_pointer_out == '0)) else $error("circular wrap wrong");
   AST_IDLE_IGNORES: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!dma_active_out && !start) |=> $stable(dma_pointer_out))
      else $error("pointer moved while idle");
   AST_PTR_HOLDS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (dma_active_out && dma_enable_in && !dma_ack_in) |=> $stable(dma_pointer_out))
      else $error("pointer moved without ack");

   // Flags rise only on their own events, and fall on a clear that comes without an event in the same cycle
   AST_CLEAR_DROPS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (irq_clear_in[3] && !step) |=> !port_irq_status_out[3])
      else $error("clear ignored");
   AST_NO_SPURIOUS_BUS: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!dma_bus_fault_in && !port_irq_status_out[0]) |=> !port_irq_status_out[0])
      else $error("bus fault flag set without event");
   AST_NO_SPURIOUS_STEP: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!step && !port_irq_status_out[3]) |=> !port_irq_status_out[3])
      else $error("step flag set without ack");
   AST_NO_SPURIOUS_ACT: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      ($stable(serial_port_clock_in) && !port_irq_status_out[6]) |=> !port_irq_status_out[6])
      else $error("activity flag set without toggle");
   AST_HOLD_A_QUIET: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!holding_a_fill_in && !port_irq_status_out[4]) |=> !port_irq_status_out[4])
      else $error("holding A flag set without fill");
   AST_HOLD_B_QUIET: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!holding_b_fill_in && !port_irq_status_out[5]) |=> !port_irq_status_out[5])
      else $error("holding B flag set without fill");
   AST_ERR_QUIET: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (!overrun && !underrun && !port_irq_status_out[7]) |=> !port_irq_status_out[7])
      else $error("error flag set without cause");
endmodule
`default_nettype wire

/* File: tb/irq_service_model.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_service_model (
   input  wire logic       sys_clk_in, // Bus clock
   input  wire logic       rst_in,     // Sync reset
   input  wire logic       service_in, // Software servicing on
   input  wire logic       irq_in,     // Combined request
   input  wire logic [7:0] status_in,  // Flags read
   input  wire logic [7:0] enable_in,  // Enables set
   output logic      [7:0] clear_out   // Clear pulses
);
   // Software clears only the flags it was interrupted for
   always_ff @(posedge sys_clk_in) begin
      if (rst_in || !service_in || !irq_in) begin
         clear_out <= 8'h00;
      end else begin
         clear_out <= status_in & enable_in;
      end
   end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        sys_clk, rst, dma_en, circ, ack, fault, fa, ra, fb, ea, sclk, svc, irq, act;
   logic [11:0] last, ptr;
   logic [7:0]  en, tclr, mclr, st;
   int          mismatches, compares, n;
   logic [6:0]  evm[4] = '{7'h20, 7'h10, 7'h08, 7'h40};
   int          evb[4] = '{0, 4, 5, 6};
   tdm_port_interrupt_logic dut_u (.sys_clk_in(sys_clk), .rst_in(rst), .dma_enable_in(dma_en),
      .circular_mode_in(circ), .buffer_last_in(last), .dma_ack_in(ack), .dma_bus_fault_in(fault),
      .holding_a_fill_in(fa), .holding_a_read_in(ra), .holding_b_fill_in(fb),
      .holding_b_read_in(1'b0), .tx_empty_a_in(ea), .tx_write_a_in(1'b0), .tx_empty_b_in(1'b0),
      .tx_write_b_in(1'b0), .serial_port_clock_in(sclk), .irq_enable_in(en),
      .irq_clear_in(tclr | mclr), .port_irq_status_out(st), .chip_irq_out(irq),
      .dma_pointer_out(ptr), .dma_active_out(act));
   irq_service_model model_u (.sys_clk_in(sys_clk), .rst_in(rst), .service_in(svc),
      .irq_in(irq), .status_in(st), .enable_in(en), .clear_out(mclr));
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Bit 6 toggles the serial clock, the rest are one-cycle pulses
   task automatic pulse(input logic [6:0] m);
      @(posedge sys_clk);
      {fault, fa, fb, ea, ack, ra} <= m[5:0];
      sclk <= sclk ^ m[6];
      @(posedge sys_clk);
      {fault, fa, fb, ea, ack, ra} <= 6'h00;
      #1;
   endtask
   task automatic clr();
      @(posedge sys_clk);
      tclr <= 8'hff;
      en <= 8'h00;
      @(posedge sys_clk);
      tclr <= 8'h00;
      #1;
   endtask
   initial begin
      {rst, dma_en, circ, ack, fault, fa, ra, fb, ea, sclk, svc} = 11'h400;
      {mismatches, compares} = '0;
      last = 12'h005;
      {en, tclr} = 16'h0000;
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      #1;
      chk({4'h0, st}, 12'h000, "reset st");
      chk(ptr, 12'h000, "reset ptr");
      foreach (evm[i]) begin
         pulse(evm[i]);
         for (n = 0; n < 6 && st === 8'h00; n++) begin
            @(posedge sys_clk);
            #1;
         end
         chk({4'h0, st}, 12'h001 << evb[i], "flag");
         chk({11'h0, irq}, 12'h000, "masked");
         @(posedge sys_clk);
         en <= 8'h01 << evb[i];
         repeat (4) @(posedge sys_clk);
         #1;
         chk({11'h0, irq}, 12'h001, "enabled");
         chk({4'h0, st}, 12'h001 << evb[i], "held");
         clr();
         chk({4'h0, st}, 12'h000, "cleared");
      end
      pulse(7'h01);
      pulse(7'h10);
      chk({4'h0, st}, 12'h010, "fill after read");
      pulse(7'h10);
      chk({4'h0, st}, 12'h090, "overrun");
      clr();
      pulse(7'h04);
      chk({4'h0, st}, 12'h000, "first empty");
      pulse(7'h04);
      chk({4'h0, st}, 12'h080, "underrun");
      @(posedge sys_clk);
      {dma_en, circ} <= 2'b11;
      for (n = 0; n < 8 && act !== 1'b1; n++) begin
         @(posedge sys_clk);
         #1;
      end
      chk({11'h0, act}, 12'h001, "start");
      if (act !== 1'b1) test_done();
      for (int i = 0; i < 12; i++) begin
         clr();
         circ <= (i < 6);
         pulse(7'h02);
         chk(ptr, 12'((i + 1) % 6), "ptr");
         chk({4'h0, st}, 12'h008 | ((i % 6 == 2) ? 12'h002 : 12'h000)
            | ((i % 6 == 5) ? 12'h004 : 12'h000), "dma");
      end
      chk({11'h0, act}, 12'h000, "one-time stop");
      pulse(7'h02);
      chk(ptr, 12'h000, "idle ack");
      clr();
      @(posedge sys_clk);
      {en, svc} <= {8'hff, 1'b1};
      pulse(7'h20);
      chk({11'h0, irq}, 12'h001, "request");
      for (n = 0; n < 8 && irq !== 1'b0; n++) begin
         @(posedge sys_clk);
         #1;
      end
      chk({4'h0, st}, 12'h000, "serviced");
      test_done();
   end
endmodule
`default_nettype wire
